// >>> common/mct_pkg.sv
/*
 * shared constants and types for one channel of the multichannel
 * capture/compare timer: register offsets, field positions, reset values.
 * assumes an 8-bit register port with byte offsets.
 */
package mct_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] START_OFS = 8'h60; // shared run bits
    localparam logic [7:0] SYNC_OFS = 8'h61; // shared sync bits
    localparam logic [7:0] MODE_OFS = 8'h62; // phase flag, pair field
    localparam logic [7:0] CTRL_OFS = 8'h64; // clock, edge, clear source
    localparam logic [7:0] IO_OFS = 8'h65; // register a/b function
    localparam logic [7:0] IE_OFS = 8'h66; // interrupt enables
    localparam logic [7:0] STAT_OFS = 8'h67; // event flags
    localparam logic [7:0] CNTH_OFS = 8'h68; // counter high byte
    localparam logic [7:0] CNTL_OFS = 8'h69; // counter low byte
    localparam logic [7:0] GRAH_OFS = 8'h6A; // register a high byte
    localparam logic [7:0] GRAL_OFS = 8'h6B; // register a low byte
    localparam logic [7:0] GRBH_OFS = 8'h6C; // register b high byte
    localparam logic [7:0] GRBL_OFS = 8'h6D; // register b low byte

    // ************************************************************
    // reset values and implemented-bit masks
    // ************************************************************
    localparam logic [7:0] START_RST = 8'h00;
    localparam logic [7:0] SYNC_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h8F;
    localparam logic [7:0] CTRL_RST = 8'h80;
    localparam logic [7:0] IO_RST = 8'h88;
    localparam logic [7:0] IE_RST = 8'hF8;
    localparam logic [7:0] STAT_RST = 8'hF8;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] GR_RST = 16'hFFFF;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [7:0] START_USED = 8'h1F;
    localparam logic [7:0] MODE_USED = 8'h70;
    localparam logic [7:0] CTRL_USED = 8'h7F;
    localparam logic [7:0] IO_USED = 8'h77;
    localparam logic [7:0] IE_USED = 8'h07;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int SRC_LSB = 0; // clock source, 3 bits
    localparam int EDGE_LSB = 3; // external edge, 2 bits
    localparam int CLR_LSB = 5; // clear source, 2 bits
    localparam int IOA_LSB = 0; // register a function, 3 bits
    localparam int IOB_LSB = 4; // register b function, 3 bits
    localparam int PAIR_LSB = 4; // channel 3/4 combination, 2 bits
    localparam int PHASE_BIT = 6; // channel 2 phase counting
    localparam int FLAG_A = 0; // register a event / enable
    localparam int FLAG_B = 1; // register b event / enable
    localparam int FLAG_OV = 2; // overflow / enable

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {CLR_NONE, CLR_BY_A, CLR_BY_B, CLR_SYNC} mct_clear_type;

    typedef struct packed {
        logic [7:0] addr; // byte offset
        logic [7:0] wdata; // write data
        logic wr; // write strobe
        logic rd; // read strobe
    } mct_bus_req_type;

    // replace one byte of a 16-bit register
    function automatic logic [15:0] mct_put_byte(logic [15:0] old, logic hi, logic [7:0] b);
        mct_put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
    endfunction

    // edge choice: 00 rising, 01 falling, 1x both
    function automatic logic mct_edge_hit(logic [1:0] sel, logic rise, logic fall);
        mct_edge_hit = sel[1] ? (rise | fall) : (sel[0] ? fall : rise);
    endfunction

    // compare pin action: 00 hold, 01 low, 10 high, 11 toggle
    function automatic logic mct_cmp_pin(logic [1:0] code, logic cur);
        mct_cmp_pin = code[1] ? (code[0] ? ~cur : 1'b1) : (code[0] ? 1'b0 : cur);
    endfunction

endpackage

// >>> verification/mct_channel_tb.sv
/*
 * self-checking bench for one timer channel: register port, counting,
 * compare, capture, overflow, sync clear and mode outputs.
 * assumes mct_pkg and mct_channel with CH_IDX 0 on a single 250 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module mct_channel_tb;
    import mct_pkg::*;
    logic clk, rst_n, cap_a, cap_b, sclr, sclr_out, cmp_a, cmp_b, irq_a, irq_b, irq_ov, phase;
    logic [3:0] ext; // external clock pins a..d
    logic [1:0] pair; // pair mode output
    logic [7:0] rdata, rv; // read data, scratch
    logic [15:0] c; // scratch 16-bit value
    mct_bus_req_type req; // register request
    int n_mismatch = 0;
    int cmp_count = 0;
    mct_channel DUT (.clk(clk), .rst_n(rst_n), .bus_req(req), .rdata(rdata), .ext_clock_pin(ext),
        .capture_pin_a(cap_a), .capture_pin_b(cap_b), .sync_clear_in(sclr), .sync_clear_out(sclr_out),
        .compare_out_a(cmp_a), .compare_out_b(cmp_b), .reg_a_irq(irq_a), .reg_b_irq(irq_b),
        .overflow_irq(irq_ov), .phase_count_mode(phase), .pair_mode(pair));
    // ************************************************************
    // bus cycles and comparisons
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd16(input logic [7:0] hi, output logic [15:0] v);
        logic [7:0] h, l;
        rd(hi, h);
        rd(hi + 8'h01, l);
        v = {h, l};
    endtask
    task automatic wr16(input logic [7:0] hi, input logic [15:0] v);
        wr(hi, v[15:8]);
        wr(hi + 8'h01, v[7:0]);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [15:0] got, input int lo, input int hi, input string m);
        cmp_count++;
        if ($isunknown(got) || got < lo || got > hi) begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h range %0d..%0d", $time, m, got, lo, hi);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string m);
        rd(a, rv);
        chk({8'h00, rv}, {8'h00, exp}, m);
    endtask
    task automatic settle;
        @(posedge clk);
        #1;
    endtask
    task automatic clr_flags;
        rd(STAT_OFS, rv);
        wr(STAT_OFS, 8'hF8);
    endtask
    task automatic run(input int n);
        wr(START_OFS, 8'h01);
        repeat (n) @(posedge clk);
        wr(START_OFS, 8'h00);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        rchk(START_OFS, START_RST | ~START_USED, "start reset");
        rchk(IO_OFS, IO_RST, "io reset");
        rchk(IE_OFS, IE_RST, "ie reset");
        rchk(STAT_OFS, STAT_RST, "stat reset");
        rchk(GRAH_OFS, 8'hFF, "gra reset");
        rchk(8'h70, RD_UNMAPPED, "unmapped");
        wr(IE_OFS, 8'h00);
        rchk(IE_OFS, 8'hF8, "ie unused");
        wr(IO_OFS, 8'h00);
        rchk(IO_OFS, 8'h88, "io unused");
    endtask
    // compare match on a: drive pin, clear counter, flag, gated request
    task automatic t_compare;
        logic [15:0] c2;
        wr16(CNTH_OFS, 16'h0000);
        wr16(GRAH_OFS, 16'h0005);
        wr(CTRL_OFS, 8'h20);
        wr(IO_OFS, 8'h02);
        clr_flags;
        run(20);
        settle;
        chk(cmp_a, 1'b1, "pin high");
        chk(irq_a, 1'b0, "irq masked");
        rd16(CNTH_OFS, c);
        chk_rng(c, 0, 5, "clear by a");
        repeat (10) @(posedge clk);
        rd16(CNTH_OFS, c2);
        chk(c2, c, "halted");
        rchk(STAT_OFS, 8'hF9, "flag a");
        wr(IE_OFS, 8'h01);
        settle;
        chk(irq_a, 1'b1, "irq on");
        wr(STAT_OFS, 8'hFF);
        settle;
        chk(irq_a, 1'b1, "write one");
        clr_flags;
        settle;
        chk(irq_a, 1'b0, "flag cleared");
        wr(IO_OFS, 8'h01);
        run(20);
        settle;
        chk(cmp_a, 1'b0, "pin low");
        wr(SYNC_OFS, 8'h01);
        wr16(CNTH_OFS, 16'h0005);
        wr16(GRBH_OFS, 16'h0005);
        wr(IO_OFS, 8'h23);
        wr(START_OFS, 8'h01);
        #1 chk(sclr_out, 1'b1, "sync out");
        wr(START_OFS, 8'h00);
        settle;
        chk(cmp_a, 1'b1, "pin toggle");
        chk(cmp_b, 1'b1, "pin b high");
    endtask
    task automatic t_overflow;
        wr16(CNTH_OFS, 16'hFFFE);
        wr(CTRL_OFS, 8'h00);
        wr(IE_OFS, 8'h04);
        clr_flags;
        run(4);
        settle;
        chk(irq_ov, 1'b1, "overflow irq");
        rd16(CNTH_OFS, c);
        chk_rng(c, 0, 8, "wrap");
        wr(IE_OFS, 8'h00);
        settle;
        chk(irq_ov, 1'b0, "overflow masked");
    endtask
    // a falling capture, b rising capture on the same pin moves
    task automatic t_capture;
        wr(IE_OFS, 8'h02);
        clr_flags;
        wr16(CNTH_OFS, 16'h1234);
        wr(IO_OFS, 8'h45);
        @(posedge clk);
        cap_a <= 1'b1;
        cap_b <= 1'b1;
        repeat (6) @(posedge clk);
        wr16(CNTH_OFS, 16'h2345);
        cap_a <= 1'b0;
        cap_b <= 1'b0;
        repeat (6) @(posedge clk);
        rd16(GRAH_OFS, c);
        chk(c, 16'h2345, "capture a");
        rd16(GRBH_OFS, c);
        chk(c, 16'h1234, "capture b");
        settle;
        chk(irq_b, 1'b1, "irq b");
        chk(irq_a, 1'b0, "irq a masked");
        wr16(CNTH_OFS, 16'h3456);
        wr(IO_OFS, 8'h47);
        cap_a <= 1'b1;
        repeat (6) @(posedge clk);
        rd16(GRAH_OFS, c);
        chk(c, 16'h3456, "code 111 rise");
    endtask
    task automatic t_divider;
        for (int s = 0; s < 4; s++) begin
            wr16(CNTH_OFS, 16'h0000);
            wr(CTRL_OFS, 8'(s));
            run(32);
            rd16(CNTH_OFS, c);
            chk_rng(c, 32 >> s, (35 >> s) + 1, "divider");
        end
    endtask
    // pin i with edge code i: rise, fall, both, both
    task automatic t_ext;
        for (int i = 0; i < 4; i++) begin
            wr16(CNTH_OFS, 16'h0000);
            wr(CTRL_OFS, {3'b000, 2'(i), 1'b1, 2'(i)});
            wr(START_OFS, 8'h01);
            repeat (4) begin
                @(posedge clk);
                ext[i] <= 1'b1;
                repeat (4) @(posedge clk);
                ext[i] <= 1'b0;
                repeat (4) @(posedge clk);
            end
            repeat (6) @(posedge clk);
            wr(START_OFS, 8'h00);
            rd16(CNTH_OFS, c);
            chk(c, (i < 2) ? 16'h0004 : 16'h0008, "ext edges");
        end
    endtask
    task automatic t_sync;
        for (int k = 0; k < 2; k++) begin
            wr16(CNTH_OFS, 16'h0100);
            wr(SYNC_OFS, 8'(k));
            wr(CTRL_OFS, 8'h60);
            wr(START_OFS, 8'h01);
            @(posedge clk);
            sclr <= 1'b1;
            @(posedge clk);
            sclr <= 1'b0;
            wr(START_OFS, 8'h00);
            rd16(CNTH_OFS, c);
            chk_rng(c, k ? 0 : 256, k ? 8 : 288, "sync clear");
        end
    endtask
    task automatic t_mode;
        wr(MODE_OFS, 8'h70);
        settle;
        chk({phase, pair}, 3'b111, "phase and pwm");
        wr(MODE_OFS, 8'h20);
        settle;
        chk({phase, pair}, 3'b010, "complementary");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ************************************************************
    // clock, watchdog, main sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        rst_n = 1'b0;
        req = '0;
        ext = 4'h0;
        cap_a = 1'b0;
        cap_b = 1'b0;
        sclr = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_compare;
        t_overflow;
        t_capture;
        t_divider;
        t_ext;
        t_sync;
        t_mode;
        report_and_stop;
    end
endmodule
`default_nettype wire

// >>> verilog/mct_channel.sv
/*
 * one channel of the multichannel capture/compare timer, together with
 * the shared run, sync and mode registers.
 * assumes: pins are asynchronous and are synchronised here; the sync
 * clear input comes from the other channels on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module mct_channel
    import mct_pkg::*;
#(
    parameter int CH_IDX = 0, // this channel's bit in shared registers
    parameter int NUM_CH = 5 // channels sharing run and sync bits
) (
    input wire logic clk, // 250 MHz system clock
    input wire logic rst_n, // async reset, active low
    input wire mct_bus_req_type bus_req, // register request
    output logic [7:0] rdata, // read data, cycle after read
    input wire logic [3:0] ext_clock_pin, // external clock pins a..d
    input wire logic capture_pin_a, // register a capture input
    input wire logic capture_pin_b, // register b capture input
    input wire logic sync_clear_in, // clear from another synced channel
    output logic sync_clear_out, // this channel clears, pulse
    output logic compare_out_a, // register a compare pin
    output logic compare_out_b, // register b compare pin
    output logic reg_a_irq, // register a request, level
    output logic reg_b_irq, // register b request, level
    output logic overflow_irq, // overflow request, level
    output logic phase_count_mode, // channel 2 phase counting
    output logic [1:0] pair_mode // channel 3/4 combination
);

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] start_q; // shared run bits
    logic [7:0] sync_q; // shared sync bits
    logic [7:0] mode_q; // mode register
    logic [7:0] ctrl_q; // clock/clear control
    logic [7:0] io_q; // register functions
    logic [7:0] ie_q; // interrupt enables
    logic [2:0] flag_q; // event flags
    logic [2:0] armed_q; // flags seen as one by a read
    logic [15:0] cnt_q; // channel counter
    logic [15:0] gra_q; // general register a
    logic [15:0] grb_q; // general register b
    logic [2:0] presc_q; // internal divider
    logic out_a_q; // compare pin a
    logic out_b_q; // compare pin b
    logic [7:0] rdata_q; // read data
    // pin synchroniser stages
    logic [3:0] ext_s1_q, ext_s2_q, ext_s3_q; // clock pin sync + delay
    logic [1:0] cap_s1_q, cap_s2_q, cap_s3_q; // capture pin sync + delay

    // ************************************************************
    // register decode
    // ************************************************************
    // fields of the bus request
    wire logic wr = bus_req.wr;
    wire logic rd = bus_req.rd;
    wire logic [7:0] addr = bus_req.addr;
    wire logic [7:0] wdata = bus_req.wdata;
    // 16-bit registers, two offsets
    wire logic wr_cnt = wr && (addr == CNTH_OFS || addr == CNTL_OFS);
    wire logic wr_gra = wr && (addr == GRAH_OFS || addr == GRAL_OFS);
    wire logic wr_grb = wr && (addr == GRBH_OFS || addr == GRBL_OFS);
    wire logic wr_stat = wr && addr == STAT_OFS;
    wire logic hi_byte = ~addr[0]; // even offset is high byte

    // ************************************************************
    // field decode
    // ************************************************************
    // this channel's shared bits
    wire logic run = start_q[CH_IDX];
    wire logic sync_on = sync_q[CH_IDX];
    // clock source field
    wire logic [2:0] src = ctrl_q[SRC_LSB +: 3];
    // edge and clear selects
    wire logic [1:0] edge_sel = ctrl_q[EDGE_LSB +: 2];
    wire mct_clear_type clr_src = mct_clear_type'(ctrl_q[CLR_LSB +: 2]);
    // register a and b functions
    wire logic [2:0] ioa = io_q[IOA_LSB +: 3];
    wire logic [2:0] iob = io_q[IOB_LSB +: 3];

    // ************************************************************
    // clock selection
    // ************************************************************
    // divide mask: 000, 001, 011, 111 for /1 /2 /4 /8
    wire logic [2:0] div_mask = 3'((4'h1 << src[1:0]) - 4'h1);
    wire logic int_tick = (presc_q & div_mask) == div_mask;
    // pin edges from stages 2, 3
    wire logic [3:0] ext_rise = ext_s2_q & ~ext_s3_q;
    wire logic [3:0] ext_fall = ~ext_s2_q & ext_s3_q;
    // low source bits pick the pin
    wire logic ext_tick = mct_edge_hit(edge_sel, ext_rise[src[1:0]], ext_fall[src[1:0]]);
    // stopped: no tick at all
    wire logic cnt_tick = run && (src[2] ? ext_tick : int_tick);

    // ************************************************************
    // match and capture events
    // ************************************************************
    // capture pin edges
    wire logic [1:0] cap_rise = cap_s2_q & ~cap_s3_q;
    wire logic [1:0] cap_fall = ~cap_s2_q & cap_s3_q;
    // code 111 falls into the both-edges arm
    wire logic cap_a = ioa[2] && mct_edge_hit(ioa[1:0], cap_rise[0], cap_fall[0]);
    wire logic cap_b = iob[2] && mct_edge_hit(iob[1:0], cap_rise[1], cap_fall[1]);
    // compare only on a counting edge
    wire logic match_a = !ioa[2] && cnt_tick && cnt_q == gra_q;
    wire logic match_b = !iob[2] && cnt_tick && cnt_q == grb_q;
    // either event raises the flag
    wire logic event_a = match_a || cap_a;
    wire logic event_b = match_b || cap_b;
    // own and shared clear sources
    wire logic own_clear = (clr_src == CLR_BY_A && event_a) || (clr_src == CLR_BY_B && event_b);
    wire logic sync_clear = clr_src == CLR_SYNC && sync_on && sync_clear_in;
    wire logic hw_clear = own_clear || sync_clear;
    // wrap only if no clear wins
    wire logic ovf_evt = cnt_tick && cnt_q == CNT_MAX && !hw_clear;

    // ************************************************************
    // next values
    // ************************************************************
    // write beats clear beats count
    wire logic [15:0] cnt_d = wr_cnt ? mct_put_byte(cnt_q, hi_byte, wdata) :
                              hw_clear ? CNT_RST :
                              cnt_tick ? cnt_q + 16'h0001 : cnt_q;
    // a capture edge wins over a software write in the same cycle
    wire logic [15:0] gra_d = cap_a ? cnt_q : wr_gra ? mct_put_byte(gra_q, hi_byte, wdata) : gra_q;
    wire logic [15:0] grb_d = cap_b ? cnt_q : wr_grb ? mct_put_byte(grb_q, hi_byte, wdata) : grb_q;
    // clear only bits written 0 after being read as 1; set wins
    wire logic [2:0] flag_clr = wr_stat ? (~wdata[2:0] & armed_q) : 3'h0;
    wire logic [2:0] flag_set = {ovf_evt, event_b, event_a};
    wire logic [2:0] flag_d = (flag_q & ~flag_clr) | flag_set;
    // a status read arms the ones seen
    wire logic [2:0] armed_d = (rd && addr == STAT_OFS) ? flag_q : (wr_stat ? 3'h0 : armed_q);
    // pins change only on a match
    wire logic out_a_d = match_a ? mct_cmp_pin(ioa[1:0], out_a_q) : out_a_q;
    wire logic out_b_d = match_b ? mct_cmp_pin(iob[1:0], out_b_q) : out_b_q;

    // ************************************************************
    // read mux; unused bits read as one
    // ************************************************************
    // registered below, stands one cycle
    logic [7:0] rd_mux;
    always_comb begin
        unique case (addr)
            START_OFS: rd_mux = start_q | ~START_USED;
            SYNC_OFS: rd_mux = sync_q | ~START_USED;
            MODE_OFS: rd_mux = mode_q | ~MODE_USED;
            CTRL_OFS: rd_mux = ctrl_q | ~CTRL_USED;
            IO_OFS: rd_mux = io_q | ~IO_USED;
            IE_OFS: rd_mux = ie_q | ~IE_USED;
            STAT_OFS: rd_mux = {5'h1F, flag_q};
            CNTH_OFS: rd_mux = cnt_q[15:8];
            CNTL_OFS: rd_mux = cnt_q[7:0];
            GRAH_OFS: rd_mux = gra_q[15:8];
            GRAL_OFS: rd_mux = gra_q[7:0];
            GRBH_OFS: rd_mux = grb_q[15:8];
            GRBL_OFS: rd_mux = grb_q[7:0];
            // unmapped offsets read zero
            default: rd_mux = RD_UNMAPPED;
        endcase
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    // stage 1 feeds stage 2 only; edges come from stages 2 and 3
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // idle level of the pins
            ext_s1_q <= 4'h0;
            ext_s2_q <= 4'h0;
            ext_s3_q <= 4'h0;
            cap_s1_q <= 2'h0;
            cap_s2_q <= 2'h0;
            cap_s3_q <= 2'h0;
        end else begin
            // stage 1 read by stage 2 only
            ext_s1_q <= ext_clock_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            cap_s1_q <= {capture_pin_b, capture_pin_a};
            cap_s2_q <= cap_s1_q;
            cap_s3_q <= cap_s2_q;
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    // run and sync bits shared by channels
    // writes keep implemented bits only; unused bits ignore writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= START_RST;
            sync_q <= SYNC_RST;
            mode_q <= MODE_RST & MODE_USED;
            ctrl_q <= CTRL_RST & CTRL_USED;
            io_q <= IO_RST & IO_USED;
            ie_q <= IE_RST & IE_USED;
        end else if (wr) begin
            if (addr == START_OFS) start_q <= wdata & START_USED;
            if (addr == SYNC_OFS) sync_q <= wdata & START_USED;
            if (addr == MODE_OFS) mode_q <= wdata & MODE_USED;
            if (addr == CTRL_OFS) ctrl_q <= wdata & CTRL_USED;
            if (addr == IO_OFS) io_q <= wdata & IO_USED;
            if (addr == IE_OFS) ie_q <= wdata & IE_USED;
        end
    end

    // ************************************************************
    // counter, general registers, flags, pins
    // ************************************************************
    // all datapath state, one process
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_q <= 3'h0;
            cnt_q <= CNT_RST;
            gra_q <= GR_RST;
            grb_q <= GR_RST;
            flag_q <= STAT_RST[2:0];
            armed_q <= 3'h0;
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            // divider runs even while stopped
            presc_q <= presc_q + 3'h1;
            cnt_q <= cnt_d;
            gra_q <= gra_d;
            grb_q <= grb_d;
            flag_q <= flag_d;
            armed_q <= armed_d;
            out_a_q <= out_a_d;
            out_b_q <= out_b_d;
            // zero outside a read answer
            rdata_q <= rd ? rd_mux : 8'h00;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // data and compare outputs straight from flops; sync clear out is logic
    assign rdata = rdata_q;
    assign compare_out_a = out_a_q;
    assign compare_out_b = out_b_q;
    assign sync_clear_out = sync_on && own_clear;
    // requests: flag and enable, level
    assign reg_a_irq = flag_q[FLAG_A] && ie_q[FLAG_A];
    assign reg_b_irq = flag_q[FLAG_B] && ie_q[FLAG_B];
    assign overflow_irq = flag_q[FLAG_OV] && ie_q[FLAG_OV];
    // modes reported only, not built
    assign phase_count_mode = mode_q[PHASE_BIT];
    assign pair_mode = mode_q[PAIR_LSB +: 2];

    // ************************************************************
    // assertions
    // ************************************************************
    // one clock; reset disables checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // stopped counter holds
    property p_hold_stopped;
        !run && !wr_cnt && !hw_clear |=> $stable(cnt_q);
    endproperty
    a_hold_stopped: assert property (p_hold_stopped) else $error("counter moved while stopped");

    // undivided clock counts each edge
    property p_div1_count;
        run && src == 3'h0 && !wr_cnt && !hw_clear |=> cnt_q == $past(cnt_q) + 16'h0001;
    endproperty
    a_div1_count: assert property (p_div1_count) else $error("undivided clock missed a count");

    // match on a clears counter
    property p_clear_by_a;
        clr_src == CLR_BY_A && match_a && !wr_cnt |=> cnt_q == CNT_RST;
    endproperty
    a_clear_by_a: assert property (p_clear_by_a) else $error("no clear on register a match");

    // clear from synced channels
    property p_sync_clear;
        sync_clear && !wr_cnt |=> cnt_q == CNT_RST;
    endproperty
    a_sync_clear: assert property (p_sync_clear) else $error("synchronous clear missed");

    // toggle code flips pin a
    property p_toggle_a;
        match_a && ioa == 3'h3 |=> compare_out_a != $past(compare_out_a);
    endproperty
    a_toggle_a: assert property (p_toggle_a) else $error("compare pin a did not toggle");

    // captured count lands in b
    property p_capture_b;
        cap_b |=> grb_q == $past(cnt_q) && flag_q[FLAG_B];
    endproperty
    a_capture_b: assert property (p_capture_b) else $error("register b capture wrong");

    // no register a or overflow request past a zero enable
    property p_irq_gate;
        (reg_a_irq |-> ie_q[FLAG_A]) and (overflow_irq |-> ie_q[FLAG_OV]);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request passed a disabled enable");

    // wrap raises overflow flag
    property p_ovf_set;
        ovf_evt |=> flag_q[FLAG_OV] && cnt_q == CNT_RST;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

    // writing one keeps flags
    property p_write_one_kept;
        wr_stat && wdata[2:0] == 3'h7 |=> (flag_q & $past(flag_q)) == $past(flag_q);
    endproperty
    a_write_one_kept: assert property (p_write_one_kept) else $error("writing one cleared a flag");

    // unused enable bits read one
    property p_unused_ones;
        rd && addr == IE_OFS |=> rdata[7:3] == 5'h1F;
    endproperty
    a_unused_ones: assert property (p_unused_ones) else $error("unused enable bits not one");

    // captured count lands in a
    property p_capture_a;
        cap_a |=> gra_q == $past(cnt_q) && flag_q[FLAG_A];
    endproperty
    a_capture_a: assert property (p_capture_a) else $error("register a capture wrong");

    // drive-high code sets pin b
    property p_high_b;
        match_b && iob == 3'h2 |=> compare_out_b;
    endproperty
    a_high_b: assert property (p_high_b) else $error("compare pin b not high");

    // armed flag written zero clears
    property p_flag_clear_a;
        wr_stat && !wdata[FLAG_A] && armed_q[FLAG_A] && !event_a |=> !flag_q[FLAG_A];
    endproperty
    a_flag_clear_a: assert property (p_flag_clear_a) else $error("armed flag a not cleared");

    // main scenarios reached
    c_overflow: cover property (ovf_evt ##1 overflow_irq);
    c_capture_b: cover property (cap_b ##1 reg_b_irq);
    c_sync_clear: cover property (sync_clear);
    c_flag_cleared: cover property (rd && addr == STAT_OFS ##2 wr_stat ##1 flag_q == 3'h0);
    c_toggle_a: cover property (match_a && ioa == 3'h3);

endmodule

`default_nettype wire
